// >>> spcp_defines.svh
`ifndef SPCP_DEFINES_SVH
`define SPCP_DEFINES_SVH

// system clock and timing
`define SPCP_CLK_NS 8
`define SPCP_POR_NS 1000
`define SPCP_POR_CYC ((`SPCP_POR_NS + `SPCP_CLK_NS - 1) / `SPCP_CLK_NS)
`define SPCP_RESTART_NS 300
`define SPCP_RESTART_CYC ((`SPCP_RESTART_NS + `SPCP_CLK_NS - 1) / `SPCP_CLK_NS)
`define SPCP_CNT_W 8

// bitstream store
`define SPCP_ADDR_W 6
`define SPCP_MEM_BYTES 8
`define SPCP_PTR_W 3
`define SPCP_TERMINAL_COUNT 6'h3F
`define SPCP_FIFO_W 8
`define SPCP_FIFO_D 4

// jtag instruction register
`define SPCP_IR_W 4
`define SPCP_IR_CAPTURE 4'h1
`define SPCP_IR_IDCODE 4'h1
`define SPCP_IR_CONFIG 4'h7
`define SPCP_IR_ISP_ENTER 4'h8
`define SPCP_IR_ISP_LEAVE 4'h9
`define SPCP_IR_CLAMP 4'hA
`define SPCP_IR_BYPASS 4'hF
`define SPCP_DR_W 32
// arbitrary neutral identification value
`define SPCP_IDCODE_VAL 32'h0000_0001

// filtered pin vector positions
`define SPCP_PIN_N 7
`define SPCP_PIN_TCK 0
`define SPCP_PIN_TMS 1
`define SPCP_PIN_TDI 2
`define SPCP_PIN_CE_N 3
`define SPCP_PIN_HOLD 4
`define SPCP_PIN_SEL 5
`define SPCP_PIN_PAST 6

`endif

// >>> spcp_pkg.sv
package spcp_pkg;

typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
} spcp_tap_e;

endpackage

// >>> spcp_top.sv
`timescale 1ns/1ps
`include "spcp_defines.svh"

module spcp_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [W-1:0] mem_nxt [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready_r;
        pop = out_valid_r && out_ready;
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        in_ready_nxt = (cnt_nxt != (AW + 1)'(D));
        out_valid_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < D; i++) begin
                mem_r[i] <= '0;
            end
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b1;
            out_valid_r <= 1'b0;
        end else begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_ready_r <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = mem_r[rp_r];
endmodule

// Operation
// - address advances on enabled configuration clock edges
// - hold low resets counter, data floats unless clamped
// - hold line driven low during power-on
// - chip enable high: standby, reset, float unless clamped
// - restart instruction pulses restart line low
// - restart low lasts at least minimum time
// - chain enable low after terminal count
// - chain enable high on hold or disable
// - bitstream leaves on single serial pin
// - programming mode floats data unless clamped
// - mode select sampled on test clock rise
// - test data input feeds all registers
// - all registers shift onto test output
module spcp_top (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfg_clk,
    // configuration port
    input wire logic chip_enable_n,
    input wire logic clk_select,
    input wire logic hold_in,
    output logic hold_out,
    output logic hold_oe,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic chain_enable_out_n,
    output logic fpga_restart_pulse_n,
    output logic fpga_restart_oe,
    // jtag
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // bitstream load
    input wire logic load_valid,
    input wire logic [`SPCP_FIFO_W-1:0] load_data,
    output logic load_ready,
    // status
    output logic in_system_programming_active
);
    localparam int RESTART_CYC = `SPCP_RESTART_CYC;
    localparam logic [`SPCP_CNT_W-1:0] RESTART_INIT = `SPCP_CNT_W'(`SPCP_RESTART_CYC - 1);
    localparam logic [`SPCP_CNT_W-1:0] POR_INIT = `SPCP_CNT_W'(`SPCP_POR_CYC);

    // link domain
    logic [`SPCP_ADDR_W-1:0] addr_r, addr_nxt;
    logic past_r, past_nxt, data_r, data_nxt;
    logic [2:0] run_l_r;
    logic run_lf_r, run_lf_nxt;
    logic link_nrst;

    // pin filters
    logic [`SPCP_PIN_N-1:0] raw;
    logic [`SPCP_PIN_N-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt;
    logic tck_d_r;

    // system state
    logic [`SPCP_CNT_W-1:0] por_cnt_r, por_cnt_nxt, rst_cnt_r, rst_cnt_nxt;
    logic hold_oe_r, hold_oe_nxt, restart_oe_r, restart_oe_nxt;
    logic run_r, run_nxt, ceo_n_r, ceo_n_nxt, data_oe_r, data_oe_nxt;
    logic isp_r, isp_nxt, clamp_r, clamp_nxt;
    spcp_pkg::spcp_tap_e tap_r, tap_nxt;
    logic [`SPCP_IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
    logic [`SPCP_DR_W-1:0] dr_sh_r, dr_sh_nxt;
    logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
    logic [7:0] mem_r [`SPCP_MEM_BYTES];
    logic [7:0] mem_nxt [`SPCP_MEM_BYTES];
    logic [`SPCP_PTR_W-1:0] wptr_r, wptr_nxt;
    logic f_valid, f_ready;
    logic [`SPCP_FIFO_W-1:0] f_data;
    logic tck_rise, tck_fall, tms_f, tdi_f;

    function automatic spcp_pkg::spcp_tap_e tap_step(spcp_pkg::spcp_tap_e s, logic m);
        case (s)
            spcp_pkg::TAP_RESET: tap_step = m ? spcp_pkg::TAP_RESET : spcp_pkg::TAP_IDLE;
            spcp_pkg::TAP_IDLE: tap_step = m ? spcp_pkg::TAP_SEL_DR : spcp_pkg::TAP_IDLE;
            spcp_pkg::TAP_SEL_DR: tap_step = m ? spcp_pkg::TAP_SEL_IR : spcp_pkg::TAP_CAP_DR;
            spcp_pkg::TAP_CAP_DR: tap_step = m ? spcp_pkg::TAP_EXIT1_DR : spcp_pkg::TAP_SHIFT_DR;
            spcp_pkg::TAP_SHIFT_DR: tap_step = m ? spcp_pkg::TAP_EXIT1_DR : spcp_pkg::TAP_SHIFT_DR;
            spcp_pkg::TAP_EXIT1_DR: tap_step = m ? spcp_pkg::TAP_UPD_DR : spcp_pkg::TAP_PAUSE_DR;
            spcp_pkg::TAP_PAUSE_DR: tap_step = m ? spcp_pkg::TAP_EXIT2_DR : spcp_pkg::TAP_PAUSE_DR;
            spcp_pkg::TAP_EXIT2_DR: tap_step = m ? spcp_pkg::TAP_UPD_DR : spcp_pkg::TAP_SHIFT_DR;
            spcp_pkg::TAP_UPD_DR: tap_step = m ? spcp_pkg::TAP_SEL_DR : spcp_pkg::TAP_IDLE;
            spcp_pkg::TAP_SEL_IR: tap_step = m ? spcp_pkg::TAP_RESET : spcp_pkg::TAP_CAP_IR;
            spcp_pkg::TAP_CAP_IR: tap_step = m ? spcp_pkg::TAP_EXIT1_IR : spcp_pkg::TAP_SHIFT_IR;
            spcp_pkg::TAP_SHIFT_IR: tap_step = m ? spcp_pkg::TAP_EXIT1_IR : spcp_pkg::TAP_SHIFT_IR;
            spcp_pkg::TAP_EXIT1_IR: tap_step = m ? spcp_pkg::TAP_UPD_IR : spcp_pkg::TAP_PAUSE_IR;
            spcp_pkg::TAP_PAUSE_IR: tap_step = m ? spcp_pkg::TAP_EXIT2_IR : spcp_pkg::TAP_PAUSE_IR;
            spcp_pkg::TAP_EXIT2_IR: tap_step = m ? spcp_pkg::TAP_UPD_IR : spcp_pkg::TAP_SHIFT_IR;
            spcp_pkg::TAP_UPD_IR: tap_step = m ? spcp_pkg::TAP_SEL_DR : spcp_pkg::TAP_IDLE;
            default: tap_step = spcp_pkg::TAP_RESET;
        endcase
    endfunction

    // ---- link domain: address counter and data bit ----
    always_comb begin
        run_lf_nxt = (run_l_r[1] == run_l_r[2]) ? run_l_r[1] : run_lf_r;
        addr_nxt = addr_r;
        past_nxt = past_r;
        if (!run_lf_r) begin
            addr_nxt = '0;
            past_nxt = 1'b0;
        end else if (addr_r == `SPCP_TERMINAL_COUNT) begin
            past_nxt = 1'b1;
        end else begin
            addr_nxt = addr_r + 1'b1;
        end
        // bit at current address; store is frozen outside programming
        data_nxt = mem_r[addr_r[`SPCP_ADDR_W-1:3]][3'h7 - addr_r[2:0]];
    end

    // hold or disable resets link side
    // the configuration clock may stand still, so the reset must not wait for it
    assign link_nrst = nrst && run_r;

    always_ff @(posedge cfg_clk or negedge link_nrst) begin
        if (!link_nrst) begin
            run_l_r <= '0;
            run_lf_r <= 1'b0;
            addr_r <= '0;
            past_r <= 1'b0;
            data_r <= 1'b0;
        end else begin
            run_l_r <= {run_l_r[1:0], run_r};
            run_lf_r <= run_lf_nxt;
            addr_r <= addr_nxt;
            past_r <= past_nxt;
            data_r <= data_nxt;
        end
    end

    // ---- system domain: pin filters ----
    assign raw = {past_r, clk_select, hold_in, chip_enable_n, tdi, tms, tck};

    generate
        for (genvar g = 0; g < `SPCP_PIN_N; g++) begin : g_flt
            always_comb begin
                flt_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : flt_r[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            flt_r <= '0;
            tck_d_r <= 1'b0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            tck_d_r <= flt_r[`SPCP_PIN_TCK];
        end
    end

    assign tck_rise = flt_r[`SPCP_PIN_TCK] && !tck_d_r;
    assign tck_fall = !flt_r[`SPCP_PIN_TCK] && tck_d_r;
    assign tms_f = flt_r[`SPCP_PIN_TMS];
    assign tdi_f = flt_r[`SPCP_PIN_TDI];

    // ---- system domain: port control, jtag, restart ----
    always_comb begin
        por_cnt_nxt = (por_cnt_r != '0) ? por_cnt_r - 1'b1 : por_cnt_r;
        // hold line pulled low during power-on
        hold_oe_nxt = (por_cnt_nxt != '0);
        run_nxt = !flt_r[`SPCP_PIN_CE_N] && flt_r[`SPCP_PIN_HOLD] && flt_r[`SPCP_PIN_SEL]
            && !hold_oe_r;
        // chain enable from run and past flag
        ceo_n_nxt = !(run_nxt && flt_r[`SPCP_PIN_PAST]);
        tap_nxt = tap_r;
        ir_nxt = ir_r;
        ir_sh_nxt = ir_sh_r;
        dr_sh_nxt = dr_sh_r;
        tdo_nxt = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        isp_nxt = isp_r;
        clamp_nxt = clamp_r;
        restart_oe_nxt = restart_oe_r;
        rst_cnt_nxt = (rst_cnt_r != '0) ? rst_cnt_r - 1'b1 : rst_cnt_r;
        // release only after minimum low time
        if (restart_oe_r && rst_cnt_r == '0) begin
            restart_oe_nxt = 1'b0;
        end
        if (tck_rise) begin
            tap_nxt = tap_step(tap_r, tms_f);
            case (tap_r)
                spcp_pkg::TAP_RESET: begin
                    ir_nxt = `SPCP_IR_IDCODE;
                end
                spcp_pkg::TAP_CAP_IR: begin
                    ir_sh_nxt = `SPCP_IR_CAPTURE;
                end
                // shift in from test data input
                spcp_pkg::TAP_SHIFT_IR: begin
                    ir_sh_nxt = {tdi_f, ir_sh_r[`SPCP_IR_W-1:1]};
                end
                spcp_pkg::TAP_CAP_DR: begin
                    dr_sh_nxt = (ir_r == `SPCP_IR_IDCODE) ? `SPCP_IDCODE_VAL : '0;
                end
                spcp_pkg::TAP_SHIFT_DR: begin
                    if (ir_r == `SPCP_IR_IDCODE) begin
                        dr_sh_nxt = {tdi_f, dr_sh_r[`SPCP_DR_W-1:1]};
                    end else begin
                        dr_sh_nxt = {{(`SPCP_DR_W - 1){1'b0}}, tdi_f};
                    end
                end
                spcp_pkg::TAP_UPD_IR: begin
                    ir_nxt = ir_sh_r;
                    case (ir_sh_r)
                        `SPCP_IR_CONFIG: begin
                            restart_oe_nxt = 1'b1;
                            rst_cnt_nxt = RESTART_INIT;
                        end
                        `SPCP_IR_ISP_ENTER: isp_nxt = 1'b1;
                        `SPCP_IR_ISP_LEAVE: begin
                            isp_nxt = 1'b0;
                            clamp_nxt = 1'b0;
                        end
                        `SPCP_IR_CLAMP: clamp_nxt = 1'b1;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        // shift out on test clock fall
        if (tck_fall) begin
            tdo_nxt = (tap_r == spcp_pkg::TAP_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
            tdo_oe_nxt = (tap_r == spcp_pkg::TAP_SHIFT_IR) || (tap_r == spcp_pkg::TAP_SHIFT_DR);
        end
        if (clamp_r) begin
            data_oe_nxt = data_oe_r;
        end else begin
            data_oe_nxt = run_nxt && !isp_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_cnt_r <= POR_INIT;
            hold_oe_r <= 1'b1;
            run_r <= 1'b0;
            ceo_n_r <= 1'b1;
            data_oe_r <= 1'b0;
            tap_r <= spcp_pkg::TAP_RESET;
            ir_r <= `SPCP_IR_IDCODE;
            ir_sh_r <= '0;
            dr_sh_r <= '0;
            tdo_r <= 1'b1;
            tdo_oe_r <= 1'b0;
            isp_r <= 1'b0;
            clamp_r <= 1'b0;
            restart_oe_r <= 1'b0;
            rst_cnt_r <= '0;
        end else begin
            por_cnt_r <= por_cnt_nxt;
            hold_oe_r <= hold_oe_nxt;
            run_r <= run_nxt;
            ceo_n_r <= ceo_n_nxt;
            data_oe_r <= data_oe_nxt;
            tap_r <= tap_nxt;
            ir_r <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
            dr_sh_r <= dr_sh_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
            isp_r <= isp_nxt;
            clamp_r <= clamp_nxt;
            restart_oe_r <= restart_oe_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    // ---- bitstream load through fifo, drained only in programming mode ----
    spcp_fifo #(.W(`SPCP_FIFO_W), .D(`SPCP_FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(load_valid),
        .in_data(load_data),
        .in_ready(load_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_ready)
    );

    assign f_ready = isp_r;

    always_comb begin
        mem_nxt = mem_r;
        wptr_nxt = wptr_r;
        if (!isp_r) begin
            wptr_nxt = '0;
        end else if (f_valid) begin
            mem_nxt[wptr_r] = f_data;
            wptr_nxt = wptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `SPCP_MEM_BYTES; i++) begin
                mem_r[i] <= '0;
            end
            wptr_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wptr_r <= wptr_nxt;
        end
    end

    // ---- outputs ----
    assign hold_out = 1'b0;
    assign hold_oe = hold_oe_r;
    assign serial_data_out = data_r;
    assign serial_data_oe = data_oe_r;
    assign chain_enable_out_n = ceo_n_r;
    assign fpga_restart_pulse_n = 1'b0;
    assign fpga_restart_oe = restart_oe_r;
    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;
    assign in_system_programming_active = isp_r;

    // ---- assertions ----
    a_hold_por_drive: assert property (
        @(posedge clk_sys) disable iff (!nrst) (por_cnt_r > 8'h01) |=> hold_oe_r)
        else $error("hold line released during power-on");

    a_addr_held_reset: assert property (
        @(posedge cfg_clk) disable iff (!link_nrst) !run_lf_r |=> (addr_r == '0) && !past_r)
        else $error("address not reset while not running");

    a_addr_advance_one: assert property (
        @(posedge cfg_clk) disable iff (!link_nrst)
        run_lf_r && (addr_r != `SPCP_TERMINAL_COUNT) |=> addr_r == $past(addr_r) + 1'b1)
        else $error("address did not advance by one");

    a_ceo_high_idle: assert property (
        @(posedge clk_sys) disable iff (!nrst) !run_nxt |=> ceo_n_r)
        else $error("chain enable low while held or disabled");

    a_ceo_low_cause: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(ceo_n_r) |-> $past(run_nxt && flt_r[`SPCP_PIN_PAST]))
        else $error("chain enable fell without terminal count");

    a_data_float_idle: assert property (
        @(posedge clk_sys) disable iff (!nrst) !clamp_r && !run_nxt |=> !data_oe_r)
        else $error("data driven while disabled");

    a_data_float_isp: assert property (
        @(posedge clk_sys) disable iff (!nrst) isp_r && !clamp_r |=> !data_oe_r)
        else $error("data driven during programming");

    a_restart_start: assert property (
        @(posedge clk_sys) disable iff (!nrst) $rose(restart_oe_r) |-> rst_cnt_r == RESTART_INIT)
        else $error("restart pulse started with wrong length");

    a_restart_width: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        restart_oe_r && (rst_cnt_r != '0) |=> restart_oe_r && rst_cnt_r == $past(rst_cnt_r) - 1'b1)
        else $error("restart pulse cut short");

    a_tap_reset_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        tck_rise && tms_f && tap_r == spcp_pkg::TAP_RESET |=> tap_r == spcp_pkg::TAP_RESET)
        else $error("tap left reset with mode select high");
endmodule

// >>> spcp_fpga_model.sv
`timescale 1ns/1ps

module spcp_fpga_model (
    // serial data from the prom
    input wire logic sdo,
    input wire logic sdo_oe,
    // configuration clock and hold line
    output logic cfg_clk,
    output logic hold_low
);
    logic wire_lvl;
    logic bits_q[$];

    // undriven line shows the inverse of the last value
    assign wire_lvl = sdo_oe ? sdo : ~sdo;

    initial begin
        cfg_clk = 1'b0;
        hold_low = 1'b0;
    end

    task automatic hold(input logic v);
        hold_low = v;
    endtask

    // clock runs only within a frame, bit taken at falling edge
    task automatic frame(input int n);
        repeat (n) begin
            #62.5 cfg_clk = 1'b1;
            #62.5 cfg_clk = 1'b0;
            bits_q.push_back(wire_lvl);
        end
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "spcp_defines.svh"

module tb_top;
    logic clk_sys, nrst, chip_enable_n, clk_select, tck, tms, tdi, load_valid;
    logic [7:0] load_data;
    logic cfg_clk, hold_low, hold_in, hold_oe, serial_data_out, serial_data_oe;
    logic chain_enable_out_n, next_ce_n, fpga_restart_oe, tdo, load_ready, isp;
    logic hold_out, restart_n, restart_line, tdo_oe;
    logic [7:0] mem [8];
    int fails = 0;
    int total_checks = 0;
    int seed = 32'hF946;
    int rs_cnt = 0;
    int rs_len = 0;

    // open-drain hold line with pull-up
    assign hold_in = (hold_oe ? hold_out : 1'b1) & ~hold_low;
    // open-drain restart line with pull-up
    assign restart_line = fpga_restart_oe ? restart_n : 1'b1;
    assign next_ce_n = chain_enable_out_n;

    spcp_top uut (
        .clk_sys(clk_sys), .nrst(nrst), .cfg_clk(cfg_clk),
        .chip_enable_n(chip_enable_n), .clk_select(clk_select), .hold_in(hold_in),
        .hold_out(hold_out), .hold_oe(hold_oe), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .chain_enable_out_n(chain_enable_out_n),
        .fpga_restart_pulse_n(restart_n), .fpga_restart_oe(fpga_restart_oe),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .load_valid(load_valid), .load_data(load_data), .load_ready(load_ready),
        .in_system_programming_active(isp)
    );

    spcp_fpga_model fpga (
        .sdo(serial_data_out), .sdo_oe(serial_data_oe),
        .cfg_clk(cfg_clk), .hold_low(hold_low)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // width of the last restart pulse
    always @(negedge clk_sys) begin
        if (restart_line === 1'b0) begin
            rs_cnt <= rs_cnt + 1;
        end else if (rs_cnt != 0) begin
            rs_len <= rs_cnt;
            rs_cnt <= 0;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            fails++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one test clock period, tdo taken just before the rise
    task automatic jt(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        tck = 1'b0;
        cyc(6);
        q = tdo;
        tck = 1'b1;
        cyc(6);
    endtask

    // shift n bits through ir or dr from idle and back to idle
    task automatic sh(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
        logic q;
        dout = '0;
        jt(1'b1, 1'b0, q);
        if (ir) begin
            jt(1'b1, 1'b0, q);
        end
        jt(1'b0, 1'b0, q);
        jt(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            jt(i == n - 1, din[i], q);
            dout[i] = q;
            chk("tdo enable", 1, tdo_oe);
        end
        jt(1'b1, 1'b0, q);
        jt(1'b0, 1'b0, q);
    endtask

    task automatic ld(input logic [7:0] b);
        load_valid = 1'b1;
        load_data = b;
        while (load_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask

    // bytes msb first; allow for the start-up delay of the link domain
    task automatic rd();
        logic found;
        logic ok;
        found = 1'b0;
        for (int k = 0; k <= 10; k++) begin
            ok = 1'b1;
            for (int a = 0; a < 64; a++) begin
                if (fpga.bits_q[k + a] !== mem[a / 8][7 - a % 8]) ok = 1'b0;
            end
            if (ok) found = 1'b1;
        end
        chk("bitstream", 1, found);
        fpga.bits_q.delete();
    endtask

    initial begin
        logic [31:0] r;
        logic [31:0] din;
        logic q;
        int n;
        nrst = 1'b0;
        chip_enable_n = 1'b1;
        clk_select = 1'b1;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        load_valid = 1'b0;
        load_data = 8'h00;
        fork
            fpga.frame(1);
        join_none
        cyc(20);
        chk("chain in reset", 1, chain_enable_out_n);
        chk("hold line in reset", 0, hold_in);
        nrst = 1'b1;
        n = 0;
        while (hold_oe === 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        chk("power-on hold", 1, n >= `SPCP_POR_CYC && n <= `SPCP_POR_CYC + 2);
        for (int i = 0; i < 5; i++) jt(1'b1, 1'b0, q);
        jt(1'b0, 1'b0, q);
        sh(1'b0, 32, 32'h0000_0000, r);
        chk("idcode", `SPCP_IDCODE_VAL, r);
        chk("tdo idle", 0, tdo_oe);
        sh(1'b1, 4, `SPCP_IR_BYPASS, r);
        chk("ir capture", `SPCP_IR_CAPTURE, r);
        din = $random(seed);
        sh(1'b0, 8, din, r);
        chk("bypass", {din[6:0], 1'b0}, r);
        sh(1'b1, 4, `SPCP_IR_CONFIG, r);
        cyc(60);
        chk("restart width", `SPCP_RESTART_CYC, rs_len);
        for (int i = 0; i < 8; i++) mem[i] = $random(seed);
        for (int i = 0; i < 4; i++) ld(mem[i]);
        load_valid = 1'b0;
        cyc(2);
        chk("fifo full", 0, load_ready);
        chip_enable_n = 1'b0;
        cyc(10);
        chk("data driven", 1, serial_data_oe);
        sh(1'b1, 4, `SPCP_IR_ISP_ENTER, r);
        chk("isp flag", 1, isp);
        chk("isp float", 0, serial_data_oe);
        for (int i = 4; i < 8; i++) ld(mem[i]);
        load_valid = 1'b0;
        cyc(10);
        sh(1'b1, 4, `SPCP_IR_ISP_LEAVE, r);
        cyc(10);
        chk("isp left", 0, isp);
        chk("data back", 1, serial_data_oe);
        sh(1'b1, 4, `SPCP_IR_CLAMP, r);
        sh(1'b1, 4, `SPCP_IR_ISP_ENTER, r);
        chk("isp clamped", 1, isp);
        chk("clamped drive", 1, serial_data_oe);
        sh(1'b1, 4, `SPCP_IR_ISP_LEAVE, r);
        cyc(10);
        chk("clamp left", 1, serial_data_oe);
        fpga.bits_q.delete();
        fpga.frame(40);
        cyc(10);
        chk("chain before end", 1, next_ce_n);
        fpga.frame(36);
        cyc(10);
        chk("chain past end", 0, next_ce_n);
        rd();
        chip_enable_n = 1'b1;
        cyc(10);
        chk("chain on disable", 1, chain_enable_out_n);
        chk("standby float", 0, serial_data_oe);
        chip_enable_n = 1'b0;
        clk_select = 1'b0;
        cyc(10);
        chk("chain after reset", 1, chain_enable_out_n);
        chk("unselected float", 0, serial_data_oe);
        fpga.frame(10);
        clk_select = 1'b1;
        cyc(10);
        fpga.bits_q.delete();
        fpga.frame(76);
        cyc(10);
        rd();
        chk("chain again", 0, chain_enable_out_n);
        fpga.hold(1'b1);
        cyc(10);
        chk("chain on hold", 1, chain_enable_out_n);
        chk("hold float", 0, serial_data_oe);
        fpga.hold(1'b0);
        cyc(10);
        fpga.frame(76);
        cyc(10);
        rd();
        test_done();
    end

    initial begin
        #300000;
        fails++;
        test_done();
    end
endmodule
